// ===== rtl/prom_prog_map.vh
`ifndef PROM_PROG_MAP_VH
`define PROM_PROG_MAP_VH
// clock and timing figures
`define CLK_MHZ 200
`define T_EDGE_NS 100
`define T_FIRST_US 50
`define T_RETRY_MS 5
`define T_LIMIT_MS 400
`define T_HEAT_MS 5000
// cycle counts derived from the figures (least times round up)
`define CYC_EDGE ((`T_EDGE_NS * `CLK_MHZ + 999) / 1000 + 1)
`define CYC_FIRST (`T_FIRST_US * `CLK_MHZ)
`define CYC_RETRY (`T_RETRY_MS * 1000 * `CLK_MHZ)
`define CYC_LIMIT (`T_LIMIT_MS * 1000 * `CLK_MHZ)
`define CYC_HEAT (`T_HEAT_MS * 1000 * `CLK_MHZ)
// geometry
`define ADDR_W 9
`define DATA_W 4
`define DEPTH 512
`endif

// ===== rtl/pattern_ram.v
`timescale 1ns/1ps
// pattern store, registered read data
module pattern_ram #(
	parameter AW = 9,
	parameter DW = 4
) (
	// clock
	input wire clk,
	// write port
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	// read port
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// write and registered read
	always @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule

// ===== rtl/prom_programmer.v
// Function
// - read: address on pins, select low
// - one bit at a time, select high first
// - raise select to programming level after supply
// - after first pulse remove supply, enable, sense
// - retry with longer pulses, verify each
// - abandon when bit total reaches limit
// - repeat for every bit needing high
// - edge delays exceed minimum
// - limit total programming time per device
// - finally verify every word in sequence
`timescale 1ns/1ps
`include "prom_prog_map.vh"
module prom_programmer #(
	parameter [31:0] CYC_FIRST = `CYC_FIRST,
	parameter [31:0] CYC_RETRY = `CYC_RETRY,
	parameter [31:0] CYC_LIMIT = `CYC_LIMIT,
	parameter [31:0] CYC_HEAT = `CYC_HEAT,
	parameter [31:0] CYC_EDGE = `CYC_EDGE
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// pattern load
	input wire load_en,
	input wire [8:0] load_addr,
	input wire [3:0] load_data,
	// command and status
	input wire start,
	output reg busy,
	output reg done,
	output reg fail_fuse,
	output reg fail_verify,
	output reg fail_heat,
	output reg [8:0] fail_addr,
	// target pins
	output reg [8:0] prom_addr,
	output reg select_n,
	output reg select_hv,
	output reg [3:0] out_hv,
	input wire [3:0] prom_data
);
	localparam S_IDLE = 4'h0;
	localparam S_RDPAT = 4'h1;
	localparam S_SENSE = 4'h2;
	localparam S_DESEL = 4'h3;
	localparam S_SUPPLY = 4'h4;
	localparam S_PULSE = 4'h5;
	localparam S_DROPHV = 4'h6;
	localparam S_DROPSUP = 4'h7;
	localparam S_CHECK = 4'h8;
	localparam S_VREAD = 4'h9;
	localparam S_VCMP = 4'ha;
	localparam S_END = 4'hb;

	reg [3:0] state;
	reg [31:0] wait_cnt;
	reg [31:0] bit_time;
	reg [31:0] dev_time;
	reg [1:0] bit_idx;
	reg first;
	reg [3:0] sync1;
	reg [3:0] sync2;
	wire [3:0] pat;
	reg [8:0] rd_addr;

	pattern_ram #(.AW(9), .DW(4)) pattern_ram_inst (
		.clk(clk),
		.wr_en(load_en & ~busy),
		.wr_addr(load_addr),
		.wr_data(load_data),
		.rd_addr(rd_addr),
		.rd_data(pat)
	);

	// pin synchroniser
	always @(posedge clk)
	begin
		sync1 <= prom_data;
		sync2 <= sync1;
	end

	// read address follows target address
	always @*
	begin
		rd_addr = prom_addr;
	end

	// sequencer
	always @(posedge clk)
	begin
		if (rst)
		begin
			state <= S_IDLE;
			busy <= 1'b0;
			done <= 1'b0;
			fail_fuse <= 1'b0;
			fail_verify <= 1'b0;
			fail_heat <= 1'b0;
			fail_addr <= 9'h000;
			prom_addr <= 9'h000;
			select_n <= 1'b1;
			select_hv <= 1'b0;
			out_hv <= 4'h0;
			wait_cnt <= 32'h0;
			bit_time <= 32'h0;
			dev_time <= 32'h0;
			bit_idx <= 2'h0;
			first <= 1'b1;
		end
		else
		begin
			if (wait_cnt != 32'h0)
				wait_cnt <= wait_cnt - 32'h1;
			if (select_hv)
				dev_time <= dev_time + 32'h1;
			case (state)
				S_IDLE:
				begin
					select_n <= 1'b1;
					if (start)
					begin
						busy <= 1'b1;
						done <= 1'b0;
						fail_fuse <= 1'b0;
						fail_verify <= 1'b0;
						fail_heat <= 1'b0;
						prom_addr <= 9'h000;
						bit_idx <= 2'h0;
						dev_time <= 32'h0;
						state <= S_RDPAT;
					end
				end
				S_RDPAT:
				begin
					// enable target and let read and pattern settle
					select_n <= 1'b0;
					wait_cnt <= CYC_EDGE + 32'h2;
					bit_time <= 32'h0;
					first <= 1'b1;
					state <= S_SENSE;
				end
				S_SENSE:
					if (wait_cnt == 32'h0)
					begin
						// blank reads low; fuse only bits wanted high and still low
						if (pat[bit_idx] & ~sync2[bit_idx])
						begin
							if (bit_time >= CYC_LIMIT)
							begin
								fail_fuse <= 1'b1;
								fail_addr <= prom_addr;
								state <= S_END;
							end
							else if (dev_time >= CYC_HEAT)
							begin
								fail_heat <= 1'b1;
								fail_addr <= prom_addr;
								state <= S_END;
							end
							else
							begin
								select_n <= 1'b1;
								wait_cnt <= CYC_EDGE;
								state <= S_DESEL;
							end
						end
						else if (bit_idx != 2'h3)
						begin
							bit_idx <= bit_idx + 2'h1;
							bit_time <= 32'h0;
							first <= 1'b1;
						end
						else if (prom_addr != 9'h1ff)
						begin
							bit_idx <= 2'h0;
							prom_addr <= prom_addr + 9'h001;
							state <= S_RDPAT;
						end
						else
						begin
							prom_addr <= 9'h000;
							state <= S_VREAD;
						end
					end
				S_DESEL:
					if (wait_cnt == 32'h0)
					begin
						out_hv <= 4'h1 << bit_idx;
						wait_cnt <= CYC_EDGE;
						state <= S_SUPPLY;
					end
				S_SUPPLY:
					if (wait_cnt == 32'h0)
					begin
						select_hv <= 1'b1;
						wait_cnt <= first ? CYC_FIRST : CYC_RETRY;
						state <= S_PULSE;
					end
				S_PULSE:
				begin
					bit_time <= bit_time + 32'h1;
					if (wait_cnt == 32'h0)
					begin
						select_hv <= 1'b0;
						first <= 1'b0;
						wait_cnt <= CYC_EDGE;
						state <= S_DROPHV;
					end
				end
				S_DROPHV:
					if (wait_cnt == 32'h0)
					begin
						out_hv <= 4'h0;
						wait_cnt <= CYC_EDGE;
						state <= S_DROPSUP;
					end
				S_DROPSUP:
					if (wait_cnt == 32'h0)
					begin
						select_n <= 1'b0;
						wait_cnt <= CYC_EDGE + 32'h2;
						state <= S_SENSE;
					end
				S_VREAD:
				begin
					select_n <= 1'b0;
					wait_cnt <= CYC_EDGE + 32'h2;
					state <= S_VCMP;
				end
				S_VCMP:
					if (wait_cnt == 32'h0)
					begin
						if (sync2 != pat)
						begin
							fail_verify <= 1'b1;
							fail_addr <= prom_addr;
							state <= S_END;
						end
						else if (prom_addr == 9'h1ff)
							state <= S_END;
						else
						begin
							prom_addr <= prom_addr + 9'h001;
							state <= S_VREAD;
						end
					end
				S_END:
				begin
					select_n <= 1'b1;
					select_hv <= 1'b0;
					out_hv <= 4'h0;
					busy <= 1'b0;
					done <= 1'b1;
					state <= S_IDLE;
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== verif/prom_model.sv
`timescale 1ns/1ps
module prom_model #(
	parameter [8:0] SLOW = 9'h005,
	parameter [8:0] DEAD = 9'h1ff
) (
	// target pins
	input wire [8:0] addr,
	input wire select_n,
	input wire select_hv,
	input wire [3:0] out_hv,
	output wire [3:0] data
);
reg [3:0] fuse [0:511];
reg tries;
integer i;
// blank array
initial
begin
	tries = 1'b0;
	for (i = 0; i < 512; i = i + 1)
		fuse[i] = 4'h0;
end
// pulse end opens the fuse under supply
// the reset edge out of an unknown level carries no supply and is ignored
always @(negedge select_hv)
	if (|out_hv === 1'b1)
	begin
		if (addr != DEAD && (addr != SLOW || tries))
			fuse[addr] <= fuse[addr] | out_hv;
		else
			tries <= 1'b1;
	end
// off outputs pulled high
assign data = select_n ? 4'hf : fuse[addr];
endmodule

// ===== verif/prom_checker_properties.sv
`timescale 1ns/1ps
module prom_checker #(
	parameter [31:0] CYC_FIRST = 20,
	parameter [31:0] CYC_EDGE = 2
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// target pins
	input wire [8:0] prom_addr,
	input wire select_n,
	input wire select_hv,
	input wire [3:0] out_hv
);
reg [31:0] hv_len;
reg [5:0] pins_q;
reg [31:0] quiet;
// cycles since any programming pin last moved
always @(posedge clk)
begin
	pins_q <= {select_n, select_hv, out_hv};
	quiet <= (rst || pins_q != {select_n, select_hv, out_hv}) ? 32'h0 : quiet + 32'h1;
end
// pulse length
always @(posedge clk)
	hv_len <= (rst || !select_hv) ? 32'h0 : hv_len + 32'h1;
default clocking @(posedge clk); endclocking
default disable iff (rst);
property p_one; $onehot0(out_hv); endproperty
a_one: assert property (p_one) else $error("two supplies");
property p_sel; |out_hv |-> select_n; endproperty
a_sel: assert property (p_sel) else $error("supply while enabled");
property p_gate; select_hv |-> |out_hv && $stable(out_hv); endproperty
a_gate: assert property (p_gate) else $error("gate without supply");
property p_len; $fell(select_hv) |-> hv_len >= CYC_FIRST; endproperty
a_len: assert property (p_len) else $error("short pulse");
property p_drop; $fell(select_hv) |-> |out_hv; endproperty
a_drop: assert property (p_drop) else $error("supply dropped early");
property p_sense; !select_n |-> !select_hv; endproperty
a_sense: assert property (p_sense) else $error("gate while sensing");
property p_gap; $rose(|out_hv) |-> $past(select_n) && !select_hv ##1 !select_hv; endproperty
a_gap: assert property (p_gap) else $error("edges too close");
property p_quiet; !$stable(out_hv) || !$stable(select_hv) |-> quiet >= CYC_EDGE; endproperty
a_quiet: assert property (p_quiet) else $error("edge delay below minimum");
property p_addr; select_hv |-> $stable(prom_addr); endproperty
a_addr: assert property (p_addr) else $error("address moved");
endmodule
bind prom_programmer prom_checker #(.CYC_FIRST(CYC_FIRST), .CYC_EDGE(CYC_EDGE)) prom_checker_inst (.clk(clk), .rst(rst),
	.prom_addr(prom_addr), .select_n(select_n), .select_hv(select_hv), .out_hv(out_hv));

// ===== verif/prom_programmer_bench.sv
`timescale 1ns/1ps
module prom_programmer_bench;
reg clk = 0, rst = 1, load_en = 0, start = 0;
reg [8:0] load_addr = 9'h000;
reg [3:0] load_data = 4'h0;
wire busy, done, fail_fuse, fail_verify, fail_heat, select_n, select_hv;
wire [8:0] fail_addr, prom_addr;
wire [3:0] out_hv, prom_data;
integer mismatches = 0, tests_run = 0, cycles = 0, i;
// clock
initial forever #2.5 clk = ~clk;
prom_programmer #(.CYC_FIRST(20), .CYC_RETRY(50), .CYC_LIMIT(500), .CYC_HEAT(600), .CYC_EDGE(2))
	prom_programmer_inst (.clk(clk), .rst(rst), .load_en(load_en), .load_addr(load_addr),
	.load_data(load_data), .start(start), .busy(busy), .done(done), .fail_fuse(fail_fuse),
	.fail_verify(fail_verify), .fail_heat(fail_heat), .fail_addr(fail_addr), .prom_addr(prom_addr),
	.select_n(select_n), .select_hv(select_hv), .out_hv(out_hv), .prom_data(prom_data));
prom_model prom_model_inst (.addr(prom_addr), .select_n(select_n), .select_hv(select_hv),
	.out_hv(out_hv), .data(prom_data));
task conclude;
begin
	if (mismatches == 0 && tests_run > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
end
endtask
task check(input string n, input [8:0] e, input [8:0] g);
begin
	tests_run = tests_run + 1;
	if (g !== e)
	begin
		mismatches = mismatches + 1;
		$display("mismatch %s expected %h seen %h", n, e, g);
	end
end
endtask
task load(input [8:0] a, input [3:0] d);
begin
	load_en <= 1'b1;
	load_addr <= a;
	load_data <= d;
	@(posedge clk);
end
endtask
task run;
begin
	load_en <= 1'b0;
	start <= 1'b1;
	@(posedge clk);
	start <= 1'b0;
	@(posedge clk);
	check("busy", 9'h001, {8'h00, busy});
	while (!done)
		@(posedge clk);
	check("busy_done", 9'h001, {7'h00, busy, done});
end
endtask
task test_program;
begin
	for (i = 0; i < 512; i = i + 1)
		load(i[8:0], (i == 3) ? 4'ha : (i == 5) ? 4'h9 : 4'h0);
	run;
	check("flags", 9'h000, {6'h00, fail_fuse, fail_verify, fail_heat});
	check("word3", 9'h00a, {5'h00, prom_model_inst.fuse[3]});
	check("word5", 9'h009, {5'h00, prom_model_inst.fuse[5]});
	check("word4", 9'h000, {5'h00, prom_model_inst.fuse[4]});
end
endtask
task test_verify;
begin
	load(9'h003, 4'h0);
	run;
	check("flags", 9'h002, {6'h00, fail_fuse, fail_verify, fail_heat});
	check("fail_addr", 9'h003, fail_addr);
end
endtask
task test_abandon;
begin
	load(9'h003, 4'ha);
	load(9'h1ff, 4'h8);
	run;
	check("fail_fuse", 9'h001, {8'h00, fail_fuse});
	check("fail_addr", 9'h1ff, fail_addr);
end
endtask
// eight clean fuses then the dead bit push the device total over its limit
task test_heat;
begin
	load(9'h006, 4'hf);
	load(9'h007, 4'hf);
	run;
	check("flags", 9'h001, {6'h00, fail_fuse, fail_verify, fail_heat});
	check("fail_addr", 9'h1ff, fail_addr);
	check("word7", 9'h00f, {5'h00, prom_model_inst.fuse[7]});
end
endtask
// cut a hang short
always @(posedge clk)
begin
	cycles = cycles + 1;
	if (cycles == 40000)
	begin
		mismatches = mismatches + 1;
		conclude;
	end
end
// main sequence
initial
begin
	repeat (12) @(posedge clk);
	rst <= 1'b0;
	@(posedge clk);
	check("idle", 9'h100, {select_n, select_hv, out_hv, busy, done, fail_fuse});
	test_program;
	test_verify;
	test_abandon;
	test_heat;
	conclude;
end
endmodule
